// *** core/iphp_defs.vh ***
// Constants for the instruction phase and pipeline control block.
// Assumes inclusion by bare name from the design files and the checker of this block.
`ifndef IPHP_DEFS_VH
`define IPHP_DEFS_VH

// ==========================================
// Widths
`define IPHP_PC_W          11
`define IPHP_INST_W        16
`define IPHP_DATA_W        8

// ==========================================
// Clock source select codes
`define IPHP_SRC_CRYSTAL   2'h0
`define IPHP_SRC_FAST_RC   2'h1
`define IPHP_SRC_SLOW_RC   2'h2

// ==========================================
// Phase codes, one-hot
`define IPHP_PH_FETCH      4'h1
`define IPHP_PH_DECODE     4'h2
`define IPHP_PH_EXEC       4'h4
`define IPHP_PH_WRITE      4'h8

// ==========================================
// Reset values
`define IPHP_PC_RESET      11'h000
`define IPHP_NOP_WORD      16'h0000

// ==========================================
// Datapath operation codes
`define IPHP_OP_PASS       4'h0
`define IPHP_OP_ADD        4'h1
`define IPHP_OP_ADC        4'h2
`define IPHP_OP_SUB        4'h3
`define IPHP_OP_SBC        4'h4
`define IPHP_OP_AND        4'h5
`define IPHP_OP_OR         4'h6
`define IPHP_OP_XOR        4'h7
`define IPHP_OP_CPL        4'h8
`define IPHP_OP_RR         4'h9
`define IPHP_OP_RL         4'hA
`define IPHP_OP_RRC        4'hB
`define IPHP_OP_RLC        4'hC
`define IPHP_OP_INC        4'hD
`define IPHP_OP_DEC        4'hE

`endif

// *** core/iphp_alu.v ***
// Eight-bit arithmetic and logic unit with registered result.
// Assumes operands are stable while the execute phase enable is high.
`timescale 1ns/10ps
`default_nettype none
`include "iphp_defs.vh"

module iphp_alu (
	input  wire                      clk_i,
	input  wire                      reset_i,
	input  wire                      en_i,
	input  wire [3:0]                op_i,
	input  wire [`IPHP_DATA_W-1:0]   a_i,
	input  wire [`IPHP_DATA_W-1:0]   b_i,
	input  wire                      carry_i,
	output reg  [`IPHP_DATA_W-1:0]   result_o,
	output reg                       carry_o,
	output reg                       zero_o
);

	reg [`IPHP_DATA_W:0] sum_w;

	// ==========================================
	// Combinational operation
	// eight bit ALU.
	always @* begin
		sum_w = {1'b0, a_i};
		case (op_i)
			`IPHP_OP_ADD: sum_w = {1'b0, a_i} + {1'b0, b_i};
			`IPHP_OP_ADC: sum_w = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i};
			`IPHP_OP_SUB: sum_w = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
			`IPHP_OP_SBC: sum_w = {1'b0, a_i} + {1'b0, ~b_i} + {8'h00, carry_i};
			`IPHP_OP_AND: sum_w = {carry_i, a_i & b_i};
			`IPHP_OP_OR:  sum_w = {carry_i, a_i | b_i};
			`IPHP_OP_XOR: sum_w = {carry_i, a_i ^ b_i};
			`IPHP_OP_CPL: sum_w = {carry_i, ~b_i};
			`IPHP_OP_RR:  sum_w = {carry_i, b_i[0], b_i[7:1]};
			`IPHP_OP_RL:  sum_w = {carry_i, b_i[6:0], b_i[7]};
			`IPHP_OP_RRC: sum_w = {b_i[0], carry_i, b_i[7:1]};
			`IPHP_OP_RLC: sum_w = {b_i[7], b_i[6:0], carry_i};
			`IPHP_OP_INC: sum_w = {carry_i, b_i + 8'h01};
			`IPHP_OP_DEC: sum_w = {carry_i, b_i - 8'h01};
			default:      sum_w = {carry_i, b_i};
		endcase
	end

	// ==========================================
	// Result register
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			result_o <= 8'h00;
			carry_o  <= 1'b0;
			zero_o   <= 1'b0;
		end else if (en_i) begin
			result_o <= sum_w[7:0];
			carry_o  <= sum_w[8];
			zero_o   <= (sum_w[7:0] == 8'h00);
		end
	end

endmodule // iphp_alu

`default_nettype wire

// *** core/iphp_pipeline.v ***
// Four-phase instruction timing and two-stage fetch/execute pipeline control.
// Assumes program memory returns the word for fetch_addr_o while fetch_phase_o is high,
// and that the decoder outside classifies the executing word combinationally.
`timescale 1ns/10ps
`default_nettype none
`include "iphp_defs.vh"

module iphp_pipeline (
	input  wire                      clk_i,
	input  wire                      reset_i,
	input  wire                      crystal_osc_i,
	input  wire                      fast_internal_rc_i,
	input  wire                      slow_internal_rc_i,
	input  wire [1:0]                clk_src_sel_i,
	input  wire [`IPHP_INST_W-1:0]   fetch_data_i,
	input  wire                      is_branch_i,
	input  wire [`IPHP_PC_W-1:0]     branch_target_i,
	input  wire                      skip_cond_i,
	input  wire                      pc_low_write_i,
	input  wire [`IPHP_DATA_W-1:0]   pc_low_byte_i,
	input  wire [3:0]                alu_op_i,
	input  wire                      alu_dst_acc_i,
	input  wire                      mem_indirect_i,
	input  wire [`IPHP_DATA_W-1:0]   mem_direct_addr_i,
	input  wire [`IPHP_DATA_W-1:0]   mem_ptr_i,
	input  wire [`IPHP_DATA_W-1:0]   mem_rdata_i,
	output wire                      sys_tick_o,
	output wire                      fetch_phase_o,
	output wire [2:0]                execute_phases_o,
	output reg  [`IPHP_PC_W-1:0]     pc_o,
	output reg  [`IPHP_PC_W-1:0]     fetch_addr_o,
	output reg  [`IPHP_INST_W-1:0]   exec_inst_o,
	output reg                       exec_valid_o,
	output reg                       dummy_cycle_o,
	output reg  [`IPHP_DATA_W-1:0]   acc_o,
	output reg  [`IPHP_DATA_W-1:0]   mem_addr_o,
	output reg                       mem_we_o,
	output reg  [`IPHP_DATA_W-1:0]   mem_wdata_o,
	output wire                      alu_carry_o,
	output wire                      alu_zero_o
);

	// ==========================================
	// Clock source selection and synchronisation
	reg        src_level_w;
	reg  [2:0] src_sync_q;
	reg        src_state_q;
	wire       src_stable_w;

	always @* begin
		case (clk_src_sel_i)
			`IPHP_SRC_CRYSTAL: src_level_w = crystal_osc_i;
			`IPHP_SRC_FAST_RC: src_level_w = fast_internal_rc_i;
			`IPHP_SRC_SLOW_RC: src_level_w = slow_internal_rc_i;
			default:           src_level_w = crystal_osc_i;
		endcase
	end

	assign src_stable_w = (src_sync_q[1] == src_sync_q[2]);

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			src_sync_q  <= 3'h0;
			src_state_q <= 1'b0;
		end else begin
			src_sync_q <= {src_sync_q[1:0], src_level_w};
			if (src_stable_w) begin
				src_state_q <= src_sync_q[2];
			end
		end
	end

	// One system clock tick per rising edge of the selected source.
	assign sys_tick_o = src_stable_w & src_sync_q[2] & ~src_state_q;

	// ==========================================
	// Phase generator
	localparam [3:0] PH_FETCH  = `IPHP_PH_FETCH;
	localparam [3:0] PH_DECODE = `IPHP_PH_DECODE;
	localparam [3:0] PH_EXEC   = `IPHP_PH_EXEC;
	localparam [3:0] PH_WRITE  = `IPHP_PH_WRITE;

	reg  [3:0] phase_q;
	reg  [3:0] phase_d;
	wire       cycle_end_w;

	always @* begin
		phase_d = phase_q;
		if (sys_tick_o) begin
			case (phase_q)
				PH_FETCH:  phase_d = PH_DECODE;
				PH_DECODE: phase_d = PH_EXEC;
				PH_EXEC:   phase_d = PH_WRITE;
				PH_WRITE:  phase_d = PH_FETCH;
				default:   phase_d = PH_FETCH;
			endcase
		end
	end

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			phase_q <= PH_FETCH;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign fetch_phase_o    = phase_q[0];
	assign execute_phases_o = phase_q[3:1];
	assign cycle_end_w      = sys_tick_o & phase_q[3];

	// ==========================================
	// Fetch/execute pipeline
	reg                    fetched_q;
	reg                    pending_q;
	reg  [`IPHP_PC_W-1:0]  target_q;
	reg  [`IPHP_INST_W-1:0] fetch_word_q;
	wire                   redirect_w;
	wire [`IPHP_PC_W-1:0]  redirect_addr_w;

	assign redirect_addr_w = pc_low_write_i ? {pc_o[`IPHP_PC_W-1:8], pc_low_byte_i} : target_q;
	assign redirect_w = exec_valid_o & (pending_q | skip_cond_i | pc_low_write_i);

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pc_o          <= `IPHP_PC_RESET;
			fetch_addr_o  <= `IPHP_PC_RESET;
			fetch_word_q  <= `IPHP_NOP_WORD;
			exec_inst_o   <= `IPHP_NOP_WORD;
			exec_valid_o  <= 1'b0;
			fetched_q     <= 1'b0;
			dummy_cycle_o <= 1'b0;
			pending_q     <= 1'b0;
			target_q      <= `IPHP_PC_RESET;
		end else begin
			if (sys_tick_o & phase_q[0]) begin
				fetch_word_q <= fetch_data_i;
				fetched_q    <= 1'b1;
				pc_o         <= fetch_addr_o + 11'h001;
			end
			if (sys_tick_o & phase_q[1] & exec_valid_o & is_branch_i) begin
				target_q  <= branch_target_i;
				pending_q <= 1'b1;
			end
			if (cycle_end_w) begin
				if (redirect_w) begin
					exec_inst_o   <= `IPHP_NOP_WORD;
					exec_valid_o  <= 1'b0;
					dummy_cycle_o <= 1'b1;
					pending_q     <= 1'b0;
					fetch_addr_o  <= skip_cond_i & ~pending_q & ~pc_low_write_i ? pc_o : redirect_addr_w;
				end else begin
					exec_inst_o   <= fetch_word_q;
					exec_valid_o  <= fetched_q;
					dummy_cycle_o <= 1'b0;
					fetch_addr_o  <= pc_o;
				end
			end
		end
	end

	// ==========================================
	// Accumulator and data memory path
	wire [`IPHP_DATA_W-1:0] alu_res_w;
	wire                    alu_en_w;

	assign alu_en_w = sys_tick_o & phase_q[2] & exec_valid_o;

	iphp_alu u_alu (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.en_i     (alu_en_w),
		.op_i     (alu_op_i),
		.a_i      (acc_o),
		.b_i      (mem_rdata_i),
		.carry_i  (alu_carry_o),
		.result_o (alu_res_w),
		.carry_o  (alu_carry_o),
		.zero_o   (alu_zero_o)
	);

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			acc_o       <= 8'h00;
			mem_addr_o  <= 8'h00;
			mem_we_o    <= 1'b0;
			mem_wdata_o <= 8'h00;
		end else begin
			mem_we_o <= 1'b0;
			if (sys_tick_o & phase_q[1]) begin
				mem_addr_o <= mem_indirect_i ? mem_ptr_i : mem_direct_addr_i;
			end
			if (sys_tick_o & phase_q[3] & exec_valid_o) begin
				if (alu_dst_acc_i) begin
					acc_o <= alu_res_w;
				end else begin
					mem_wdata_o <= alu_res_w;
					mem_we_o    <= 1'b1;
				end
			end
		end
	end

endmodule // iphp_pipeline

`default_nettype wire

// *** testbench/iphp_pipeline_monitor.sv ***
// Checker for the phase generator and fetch/execute pipeline ports.
// Assumes it is bound into iphp_pipeline and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "iphp_defs.vh"
module iphp_pipeline_monitor (
	input wire                    clk_i,
	input wire                    reset_i,
	input wire                    sys_tick_o,
	input wire                    fetch_phase_o,
	input wire [2:0]              execute_phases_o,
	input wire [`IPHP_PC_W-1:0]   pc_o,
	input wire [`IPHP_PC_W-1:0]   fetch_addr_o,
	input wire [`IPHP_INST_W-1:0] exec_inst_o,
	input wire                    exec_valid_o,
	input wire                    dummy_cycle_o,
	input wire                    mem_we_o,
	input wire                    is_branch_i,
	input wire                    skip_cond_i,
	input wire                    pc_low_write_i,
	input wire [`IPHP_DATA_W-1:0] pc_low_byte_i
);
	// ==========
	// Phase and flush checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire last_w = sys_tick_o && execute_phases_o[2];
	wire fet_w = sys_tick_o && fetch_phase_o;
	phase_onehot_a: assert property ($onehot({execute_phases_o, fetch_phase_o}))
		else $error("phase not one-hot");
	phase_hold_a: assert property (!sys_tick_o |=> $stable({execute_phases_o, fetch_phase_o}))
		else $error("phase moved without tick");
	decode_next_a: assert property (fet_w |=> execute_phases_o == 3'h1)
		else $error("decode phase missing");
	wrap_fetch_a: assert property (last_w |=> fetch_phase_o)
		else $error("no return to fetch");
	pc_step_a: assert property (fet_w |=> pc_o == $past(fetch_addr_o) + 11'h001)
		else $error("pc not incremented");
	exec_hold_a: assert property (!last_w |=> $stable(exec_inst_o) && $stable(exec_valid_o))
		else $error("exec word moved");
	branch_flush_a: assert property (last_w && exec_valid_o && is_branch_i |=> !exec_valid_o && dummy_cycle_o)
		else $error("branch not flushed");
	skip_flush_a: assert property (last_w && exec_valid_o && skip_cond_i |=> !exec_valid_o && dummy_cycle_o)
		else $error("skip not flushed");
	page_jump_a: assert property (last_w && exec_valid_o && pc_low_write_i && !is_branch_i |=>
		fetch_addr_o == {pc_o[10:8], $past(pc_low_byte_i)} && dummy_cycle_o)
		else $error("page jump wrong");
	we_pulse_a: assert property (mem_we_o |=> !mem_we_o)
		else $error("write strobe too long");
endmodule // iphp_pipeline_monitor
bind iphp_pipeline iphp_pipeline_monitor mon (.clk_i, .reset_i, .sys_tick_o, .fetch_phase_o,
	.execute_phases_o, .pc_o, .fetch_addr_o, .exec_inst_o, .exec_valid_o, .dummy_cycle_o,
	.mem_we_o, .is_branch_i, .skip_cond_i, .pc_low_write_i, .pc_low_byte_i);
`default_nettype wire

// *** testbench/iphp_pipeline_partner.sv ***
// Program memory and decoder view seen from the pipeline.
// Assumes the bench fills prog_mem; word kind sits in bits 15:14.
`timescale 1ns/10ps
`default_nettype none
module iphp_pipeline_partner (
	input  wire        fetch_phase_i,
	input  wire [10:0] fetch_addr_i,
	input  wire [15:0] exec_inst_i,
	input  wire        exec_valid_i,
	output wire [15:0] fetch_data_o,
	output wire        branch_o,
	output wire        skip_o,
	output wire        pc_low_write_o,
	output wire [10:0] target_o,
	output wire [7:0]  pc_low_byte_o
);
	// ==========
	// Memory and decoder
	reg  [15:0] prog_mem [0:2047];
	wire [15:0] word_w = prog_mem[fetch_addr_i];
	wire [1:0]  kind_w = exec_valid_i ? exec_inst_i[15:14] : 2'h0;
	// word only in fetch phase.
	// Outside it the inverse is shown, so a late sample cannot pass by luck.
	assign fetch_data_o = fetch_phase_i ? word_w : ~word_w;
	assign branch_o = kind_w == 2'h1;
	assign skip_o = kind_w == 2'h2;
	assign pc_low_write_o = kind_w == 2'h3;
	assign target_o = exec_inst_i[10:0];
	assign pc_low_byte_o = exec_inst_i[7:0];
endmodule // iphp_pipeline_partner
`default_nettype wire

// *** testbench/iphp_pipeline_test.sv ***
// Self-checking bench: random program, instruction-level model, source switching.
// Assumes the design, its header, the partner and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module iphp_pipeline_test;
	reg         clk_i, reset_i, xo, fo, so, fl, cv, m_dst;
	reg  [1:0]  sel;
	reg  [31:0] seed, rnd;
	reg  [15:0] cw;
	integer     error_cnt, total_checks, i, n, fa, nfa, n_res;
	integer     m_acc, m_c, m_s, m_r, m_adr, alu_b;
	wire        tick, fph, val, dmy, br, sk, pw, cy, zr, mwe;
	wire [2:0]  eph;
	wire [10:0] pc, fad, tgt;
	wire [15:0] inst, fdat;
	wire [7:0]  pb, acc, madr, mwd;
	iphp_pipeline dut (.clk_i(clk_i), .reset_i(reset_i), .crystal_osc_i(xo), .fast_internal_rc_i(fo),
		.slow_internal_rc_i(so), .clk_src_sel_i(sel), .fetch_data_i(fdat), .is_branch_i(br),
		.branch_target_i(tgt), .skip_cond_i(sk), .pc_low_write_i(pw), .pc_low_byte_i(pb),
		.alu_op_i(rnd[3:0] % 4'hF), .alu_dst_acc_i(rnd[4]), .mem_indirect_i(rnd[5]),
		.mem_direct_addr_i(rnd[15:8]), .mem_ptr_i(rnd[23:16]), .mem_rdata_i(rnd[31:24]),
		.sys_tick_o(tick), .fetch_phase_o(fph), .execute_phases_o(eph), .pc_o(pc), .fetch_addr_o(fad),
		.exec_inst_o(inst), .exec_valid_o(val), .dummy_cycle_o(dmy), .acc_o(acc), .mem_addr_o(madr),
		.mem_we_o(mwe), .mem_wdata_o(mwd), .alu_carry_o(cy), .alu_zero_o(zr));
	iphp_pipeline_partner part (.fetch_phase_i(fph), .fetch_addr_i(fad), .exec_inst_i(inst),
		.exec_valid_i(val), .fetch_data_o(fdat), .branch_o(br), .skip_o(sk), .pc_low_write_o(pw),
		.target_o(tgt), .pc_low_byte_o(pb));
	// ==========
	// Clocks and random datapath stimulus
	initial forever #50 clk_i = ~clk_i;
	initial begin #37; forever #200 xo = ~xo; end
	initial begin #61; forever #250 fo = ~fo; end
	initial begin #113; forever #900 so = ~so; end
	always @(posedge clk_i) begin
		#1 rnd = $random(seed);
	end
	task fail(input [8*12-1:0] m);
		begin
			error_cnt = error_cnt + 1;
			$display("[FAIL] %0t %0s", $time, m);
		end
	endtask
	task results;
		begin
			if (error_cnt == 0 && total_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// ==========
	// Instruction-level model, one result per last-phase tick
	always @(posedge clk_i) begin
		if (reset_i) begin
			fa = 0;
			cv = 0;
			cw = 0;
		end else if (tick === 1'b1 && eph[2] === 1'b1) begin
			fl = cv && cw[15:14] != 2'h0;
			nfa = (fa + 1) & 'h7FF;
			if (fl && cw[15:14] == 2'h1) nfa = cw[10:0];
			if (fl && cw[15:14] == 2'h3) nfa = (nfa & 'h700) | cw[7:0];
			#2 total_checks = total_checks + 2;
			if (val !== !fl || dmy !== fl) fail("flush flags");
			if (fad !== nfa[10:0]) fail("fetch addr");
			if (!fl && inst !== part.prog_mem[fa]) fail("exec word");
			cw = part.prog_mem[fa];
			cv = !fl;
			fa = nfa;
			n_res = n_res + 1;
		end
	end
	// ==========
	// Datapath model: address at decode tick, result at compute tick, store at last tick
	always @(posedge clk_i) begin
		if (reset_i) begin
			m_acc = 0;
			m_c = 0;
			m_r = 0;
		end else if (tick === 1'b1 && eph[0] === 1'b1) begin
			m_adr = rnd[5] ? rnd[23:16] : rnd[15:8];
			#2 total_checks = total_checks + 1;
			if (madr !== m_adr[7:0]) fail("mem addr");
		end else if (tick === 1'b1 && eph[1] === 1'b1 && val === 1'b1) begin
			alu_b = rnd[31:24];
			case (rnd[3:0] % 4'hF)
				1:       m_s = m_acc + alu_b;
				2:       m_s = m_acc + alu_b + m_c;
				3:       m_s = m_acc + 256 - alu_b;
				4:       m_s = m_acc + 255 - alu_b + m_c;
				5:       m_s = m_c * 256 + (m_acc & alu_b);
				6:       m_s = m_c * 256 + (m_acc | alu_b);
				7:       m_s = m_c * 256 + (m_acc ^ alu_b);
				8:       m_s = m_c * 256 + 255 - alu_b;
				9:       m_s = m_c * 256 + alu_b / 2 + (alu_b % 2) * 128;
				10:      m_s = m_c * 256 + (alu_b * 2) % 256 + alu_b / 128;
				11:      m_s = (alu_b % 2) * 256 + m_c * 128 + alu_b / 2;
				12:      m_s = (alu_b / 128) * 256 + (alu_b * 2) % 256 + m_c;
				13:      m_s = m_c * 256 + (alu_b + 1) % 256;
				14:      m_s = m_c * 256 + (alu_b + 255) % 256;
				default: m_s = m_c * 256 + alu_b;
			endcase
			m_c = m_s / 256;
			m_r = m_s % 256;
			#2 total_checks = total_checks + 1;
			if (cy !== m_c[0] || zr !== (m_r == 0)) fail("alu flags");
		end else if (tick === 1'b1 && eph[2] === 1'b1 && val === 1'b1) begin
			m_dst = rnd[4];
			if (m_dst) m_acc = m_r;
			#2 total_checks = total_checks + 1;
			if (acc !== m_acc[7:0] || mwe !== !m_dst || (!m_dst && mwd !== m_r[7:0])) fail("acc or store");
		end
	end
	// ==========
	// Main sequence
	initial begin
		{clk_i, xo, fo, so, sel, rnd, error_cnt, total_checks, n_res} = 0;
		reset_i = 1;
		seed = 32'hC38F;
		for (i = 0; i < 2048; i = i + 1) begin
			rnd = $random(seed);
			n = rnd[18:16] > 3'h2 ? 0 : rnd[17:16] + 1;
			part.prog_mem[i] = {n[1:0], rnd[13:0]};
		end
		repeat (2) @(posedge clk_i);
		#1 reset_i = 0;
		while (n_res < 300) @(posedge clk_i);
		#1 reset_i = 1;
		@(posedge clk_i);
		#2 total_checks = total_checks + 1;
		if (fph !== 1'b1 || val !== 1'b0 || tick !== 1'b0) fail("reset state");
		@(posedge clk_i);
		#1 reset_i = 0;
		n_res = 0;
		while (n_res < 40) @(posedge clk_i);
		for (i = 0; i < 4; i = i + 1) begin
			#1 sel = i;
			repeat (10) @(posedge clk_i);
			n = 0;
			repeat (36) begin
				@(posedge clk_i);
				#2 n = n + (tick === 1'b1);
			end
			nfa = i == 1 ? 7 : i == 2 ? 2 : 9;
			total_checks = total_checks + 1;
			if (n < nfa - 1 || n > nfa + 1) fail("tick rate");
		end
		results;
	end
	initial begin
		#3000000 error_cnt = error_cnt + 1;
		results;
	end
endmodule // iphp_pipeline_test
`default_nettype wire
